/* File: fab_defines.vh */
`ifndef FAB_DEFINES_VH
`define FAB_DEFINES_VH
// Clock period in ps (200 MHz)
`define FAB_CLK_PS 5000
// Flash timing figures in ns
`define FAB_T_RC_NS 85
`define FAB_T_WP_NS 35
`define FAB_T_WPH_NS 30
`define FAB_T_RH_NS 50
`define FAB_T_ASO_NS 15
`define FAB_T_OEPH_NS 20
`define FAB_T_OEH_NS 10
`define FAB_T_RP_NS 500
`define FAB_T_BUSY_NS 90
// Least times round up to whole cycles
`define FAB_CYC_UP(ns) (((ns) * 1000 + `FAB_CLK_PS - 1) / `FAB_CLK_PS)
// Register offsets (word index in low address bits)
`define FAB_REG_CTRL 4'h0
`define FAB_REG_ADDR 4'h1
`define FAB_REG_WDATA 4'h2
`define FAB_REG_RDATA 4'h3
`define FAB_REG_STATUS 4'h4
`define FAB_REG_IRQ 4'h5
`define FAB_REG_MASK 4'h6
// Control command codes, bits [2:0] of CTRL write
`define FAB_CMD_READ 3'h1
`define FAB_CMD_WRITE 3'h2
`define FAB_CMD_POLL 3'h3
`define FAB_CMD_RESET 3'h4
// Interrupt bit positions
`define FAB_IRQ_DONE 0
`define FAB_IRQ_READY 1
`define FAB_IRQ_TOGGLE_STOP 2
`endif

/* File: fab_host.v */
// How it works
// - Read cycle held at least tRC.
// - Wait 50ns after reset release before reading.
// - New write right after the last one ends; ready is not checked.
// - Address set 15ns before output enable in polls.
// - Output enable high 20ns between polls.
// - Output enable waits 10ns after write strobe.
// - Write low tWP, high 30ns.
// - Toggle via output enable cycling.
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "fab_defines.vh"
module fab_host #(
    parameter AW = 22,
    parameter DW = 16,
    parameter RESET_HOLD_NS = 20000,
    parameter READY_WAIT_NS = 20000
) (
    // Clock and reset
    input wire ref_clk,
    input wire nrst,
    // Software port
    input wire [3:0] sw_addr,
    input wire [31:0] sw_wdata,
    input wire sw_wr,
    input wire sw_rd,
    output reg [31:0] sw_rdata,
    output wire irq,
    // Flash bus
    output reg [AW-1:0] fl_addr,
    output reg [DW-1:0] fl_dq_out,
    output reg fl_dq_oe,
    input wire [DW-1:0] fl_dq_in,
    output reg fl_ce_n,
    output reg fl_oe_n,
    output reg fl_we_n,
    output reg fl_reset_n,
    input wire ready_busy_out_n
);
    // Cycle counts derived from the times, rounded up so no minimum is cut
    localparam [31:0] C_RC = `FAB_CYC_UP(`FAB_T_RC_NS);
    localparam [31:0] C_WP = `FAB_CYC_UP(`FAB_T_WP_NS);
    localparam [31:0] C_WPH = `FAB_CYC_UP(`FAB_T_WPH_NS);
    localparam [31:0] C_RH = `FAB_CYC_UP(`FAB_T_RH_NS);
    localparam [31:0] C_ASO = `FAB_CYC_UP(`FAB_T_ASO_NS);
    localparam [31:0] C_OEPH = `FAB_CYC_UP(`FAB_T_OEPH_NS);
    localparam [31:0] C_OEH = `FAB_CYC_UP(`FAB_T_OEH_NS);
    localparam [31:0] C_RP = `FAB_CYC_UP(`FAB_T_RP_NS);
    localparam [31:0] C_BUSY = `FAB_CYC_UP(`FAB_T_BUSY_NS);
    // Long waits scale with the parameters; short values suit simulation only
    localparam [31:0] C_RHOLD = (RESET_HOLD_NS * 1000 + `FAB_CLK_PS - 1) / `FAB_CLK_PS;
    localparam [31:0] C_RDYW = (READY_WAIT_NS * 1000) / `FAB_CLK_PS;
    // Last counter value of each phase
    // Three extra read cycles cover the synchroniser delay on the data
    localparam [31:0] END_RD = C_RC + 32'h2;
    localparam [31:0] END_WP = C_WP - 32'h1;
    localparam [31:0] END_WPH = C_WPH - 32'h1;
    localparam [31:0] END_AS = C_ASO + C_OEH;
    localparam [31:0] END_OEPH = C_OEPH - 32'h1;
    localparam [31:0] END_RH = C_RH - 32'h1;
    localparam [31:0] END_HOLD = C_RHOLD - 32'h1;
    // States
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_RD = 4'h1;
    localparam [3:0] S_WR_LO = 4'h2;
    localparam [3:0] S_WR_HI = 4'h3;
    localparam [3:0] S_POLL_AS = 4'h4;
    localparam [3:0] S_POLL_OE = 4'h5;
    localparam [3:0] S_POLL_GAP = 4'h6;
    localparam [3:0] S_RST_LO = 4'h7;
    localparam [3:0] S_RST_WAIT = 4'h8;
    localparam [3:0] S_RST_REC = 4'h9;
    localparam [3:0] S_OEH = 4'hA;

    // Sequencer state and captured values
    reg [3:0] state;
    reg [31:0] cnt;
    reg [AW-1:0] addr_reg;
    reg [DW-1:0] wdata_reg;
    reg [DW-1:0] rdata_reg;
    reg [DW-1:0] last_poll;
    reg have_last;
    reg [2:0] irq_stat;
    reg [2:0] irq_mask;
    reg standby;
    reg timeout;
    // Synchroniser stages for the pin inputs
    reg rb_s1;
    reg rb_s2;
    reg [DW-1:0] dq_s1;
    reg [DW-1:0] dq_s2;
    // One-cycle event pulses into the sticky status
    reg [2:0] ev;
    reg rb_prev;

    // Any state but idle counts as busy; commands are refused then
    wire busy = (state != S_IDLE);
    wire cmd_go = sw_wr && (sw_addr == `FAB_REG_CTRL) && !busy;
    wire [2:0] cmd = sw_wdata[2:0];

    // Write-one-to-clear bits and the events that set status bits
    wire [2:0] clr_bits = (sw_wr && sw_addr == `FAB_REG_IRQ) ? sw_wdata[2:0] : 3'h0;
    wire [2:0] set_bits = ev | {1'b0, rb_s2 & ~rb_prev, 1'b0};
    // Set beats clear when both land in one cycle, so no event is lost
    wire [2:0] next_irq_stat = (irq_stat & ~clr_bits) | set_bits;

    // Level interrupt straight from the status and mask flops
    assign irq = |(irq_stat & irq_mask);

    // Two-flop synchronisers on all pin inputs
    always @(posedge ref_clk) begin
        if (!nrst) begin
            rb_s1 <= 1'b1;
            rb_s2 <= 1'b1;
            dq_s1 <= {DW{1'b0}};
            dq_s2 <= {DW{1'b0}};
        end else begin
            rb_s1 <= ready_busy_out_n;
            rb_s2 <= rb_s1;
            dq_s1 <= fl_dq_in;
            dq_s2 <= dq_s1;
        end
    end

    // Flash bus sequencer
    always @(posedge ref_clk) begin
        if (!nrst) begin
            state <= S_IDLE;
            cnt <= 32'h0;
            fl_addr <= {AW{1'b0}};
            fl_dq_out <= {DW{1'b0}};
            fl_dq_oe <= 1'b0;
            fl_ce_n <= 1'b1;
            fl_oe_n <= 1'b1;
            fl_we_n <= 1'b1;
            fl_reset_n <= 1'b1;
            rdata_reg <= {DW{1'b0}};
            last_poll <= {DW{1'b0}};
            have_last <= 1'b0;
            standby <= 1'b0;
            timeout <= 1'b0;
            ev <= 3'h0;
        end else begin
            ev <= 3'h0;
            case (state)
                S_IDLE: begin
                    // Commands are only taken here
                    cnt <= 32'h0;
                    if (cmd_go) begin
                        fl_addr <= addr_reg;
                        // Write may follow a read at once
                        case (cmd)
                            `FAB_CMD_READ: begin
                                fl_ce_n <= 1'b0;
                                fl_oe_n <= 1'b0;
                                state <= S_RD;
                            end
                            `FAB_CMD_WRITE: begin
                                fl_ce_n <= 1'b0;
                                fl_we_n <= 1'b0;
                                fl_dq_out <= wdata_reg;
                                fl_dq_oe <= 1'b1;
                                state <= S_WR_LO;
                            end
                            `FAB_CMD_POLL: begin
                                fl_ce_n <= 1'b0;
                                have_last <= 1'b0;
                                state <= S_POLL_AS;
                            end
                            `FAB_CMD_RESET: begin
                                fl_reset_n <= 1'b0;
                                standby <= 1'b0;
                                timeout <= 1'b0;
                                state <= S_RST_LO;
                            end
                            default: state <= S_IDLE;
                        endcase
                    end
                end

                S_RD: begin
                    // Data sampled late, after synchroniser delay
                    cnt <= cnt + 32'h1;
                    if (cnt >= END_RD) begin
                        rdata_reg <= dq_s2;
                        fl_ce_n <= 1'b1;
                        fl_oe_n <= 1'b1;
                        ev[`FAB_IRQ_DONE] <= 1'b1;
                        state <= S_IDLE;
                    end
                end

                S_WR_LO: begin
                    // Strobe low for the full pulse width
                    cnt <= cnt + 32'h1;
                    if (cnt >= END_WP) begin
                        fl_we_n <= 1'b1;
                        cnt <= 32'h0;
                        state <= S_WR_HI;
                    end
                end

                S_WR_HI: begin
                    // Keep strobe high tWPH, then back to idle without waiting the tBUSY window
                    cnt <= cnt + 32'h1;
                    if (cnt >= END_WPH) begin
                        fl_ce_n <= 1'b1;
                        fl_dq_oe <= 1'b0;
                        ev[`FAB_IRQ_DONE] <= 1'b1;
                        state <= S_IDLE;
                    end
                end

                S_POLL_AS: begin
                    // Address stands before output enable falls
                    cnt <= cnt + 32'h1;
                    if (cnt >= END_AS) begin
                        fl_oe_n <= 1'b0;
                        cnt <= 32'h0;
                        state <= S_POLL_OE;
                    end
                end

                S_POLL_OE: begin
                    cnt <= cnt + 32'h1;
                    if (cnt >= END_RD) begin
                        // Toggle bit 6 compares across reads
                        fl_oe_n <= 1'b1;
                        last_poll <= dq_s2;
                        have_last <= 1'b1;
                        cnt <= 32'h0;
                        if (have_last && (last_poll[6] == dq_s2[6])) begin
                            rdata_reg <= dq_s2;
                            fl_ce_n <= 1'b1;
                            ev[`FAB_IRQ_TOGGLE_STOP] <= 1'b1;
                            state <= S_IDLE;
                        end else begin
                            state <= S_POLL_GAP;
                        end
                    end
                end

                S_POLL_GAP: begin
                    // Erase length is unknown: poll until toggling stops
                    cnt <= cnt + 32'h1;
                    if (cnt >= END_OEPH) begin
                        fl_oe_n <= 1'b0;
                        cnt <= 32'h0;
                        state <= S_POLL_OE;
                    end
                end

                S_RST_LO: begin
                    // Pulse held long enough for standby
                    cnt <= cnt + 32'h1;
                    if (cnt >= END_HOLD && cnt >= C_RP) begin
                        standby <= 1'b1;
                        fl_reset_n <= 1'b1;
                        cnt <= 32'h0;
                        state <= S_RST_WAIT;
                    end
                end

                S_RST_WAIT: begin
                    // Ready expected within the abort bound
                    cnt <= cnt + 32'h1;
                    if (rb_s2 && cnt >= C_BUSY) begin
                        cnt <= 32'h0;
                        state <= S_RST_REC;
                    end else if (cnt >= C_RDYW) begin
                        timeout <= 1'b1;
                        cnt <= 32'h0;
                        state <= S_RST_REC;
                    end
                end

                S_RST_REC: begin
                    // No read until the recovery time has passed
                    cnt <= cnt + 32'h1;
                    if (cnt >= END_RH) begin
                        ev[`FAB_IRQ_DONE] <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // Ready edge event
    always @(posedge ref_clk) begin
        if (!nrst)
            rb_prev <= 1'b1;
        else
            rb_prev <= rb_s2;
    end

    // Software registers and sticky status; set beats clear
    always @(posedge ref_clk) begin
        if (!nrst) begin
            addr_reg <= {AW{1'b0}};
            wdata_reg <= {DW{1'b0}};
            irq_stat <= 3'h0;
            irq_mask <= 3'h0;
        end else begin
            if (sw_wr && sw_addr == `FAB_REG_ADDR)
                addr_reg <= sw_wdata[AW-1:0];
            if (sw_wr && sw_addr == `FAB_REG_WDATA)
                wdata_reg <= sw_wdata[DW-1:0];
            if (sw_wr && sw_addr == `FAB_REG_MASK)
                irq_mask <= sw_wdata[2:0];
            // Sticky value worked out beside the wires above
            irq_stat <= next_irq_stat;
        end
    end

    // Read port, data one cycle after strobe
    always @(posedge ref_clk) begin
        if (!nrst) begin
            sw_rdata <= 32'h0;
        end else if (sw_rd) begin
            case (sw_addr)
                `FAB_REG_CTRL: sw_rdata <= 32'h0;
                `FAB_REG_ADDR: sw_rdata <= {{(32-AW){1'b0}}, addr_reg};
                `FAB_REG_WDATA: sw_rdata <= {{(32-DW){1'b0}}, wdata_reg};
                `FAB_REG_RDATA: sw_rdata <= {{(32-DW){1'b0}}, rdata_reg};
                `FAB_REG_STATUS: sw_rdata <= {28'h0, timeout, standby, rb_s2, busy};
                `FAB_REG_IRQ: sw_rdata <= {29'h0, irq_stat};
                `FAB_REG_MASK: sw_rdata <= {29'h0, irq_mask};
                default: sw_rdata <= 32'h0;
            endcase
        end else begin
            sw_rdata <= 32'h0;
        end
    end
endmodule

/* File: fab_host_asserts.sv */
`timescale 1ns/10ps
module fab_host_asserts #(
    parameter AW = 22
) (
    // Clock and reset
    input wire ref_clk,
    input wire nrst,
    // Flash bus
    input wire [AW-1:0] fl_addr,
    input wire fl_dq_oe,
    input wire fl_ce_n,
    input wire fl_oe_n,
    input wire fl_we_n,
    input wire fl_reset_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    reg [7:0] oe_cnt;
    reg [7:0] we_cnt;
    // Low-time counters, saturate so long holds never wrap
    always @(posedge ref_clk) begin
        oe_cnt <= fl_oe_n ? 8'h00 : oe_cnt + {7'h00, oe_cnt != 8'hFF};
        we_cnt <= fl_we_n ? 8'h00 : we_cnt + {7'h00, we_cnt != 8'hFF};
    end
    sequence s_oe_hi2;
        fl_oe_n [*2];
    endsequence
    sequence s_we_hi6;
        fl_we_n [*6];
    endsequence
    a_read_cycle: assert property ($rose(fl_oe_n) |-> oe_cnt >= 8'h11)
        else $error("read strobe shorter than read cycle");
    a_we_low: assert property ($rose(fl_we_n) |-> we_cnt >= 8'h07)
        else $error("write pulse too short");
    a_we_high: assert property ($rose(fl_we_n) |-> s_we_hi6)
        else $error("write high time too short");
    a_oe_gap: assert property ($rose(fl_oe_n) |-> s_oe_hi2 ##1 fl_oe_n [*2])
        else $error("output enable gap too short");
    a_oe_after_we: assert property ($rose(fl_we_n) |-> s_oe_hi2)
        else $error("read too soon after write strobe");
    a_addr_setup: assert property ($fell(fl_oe_n) && !$past(fl_ce_n) |->
        $past(fl_addr, 3) == fl_addr) else $error("address not set before poll read");
    a_reset_recover: assert property ($rose(fl_reset_n) |-> s_oe_hi2 ##1 fl_oe_n [*8])
        else $error("read too soon after reset release");
    a_write_after_read: assert property ($fell(fl_we_n) |-> fl_oe_n && fl_dq_oe)
        else $error("write overlaps a read");
endmodule

/* File: fab_flash_model.sv */
`timescale 1ns/10ps
module fab_flash_model #(
    parameter PROG_CYC = 300,
    parameter STBY_CYC = 30
) (
    // Sampling clock
    input wire clk,
    // Host side bus
    input wire [21:0] addr,
    input wire [15:0] din,
    input wire din_oe,
    input wire ce_n,
    input wire oe_n,
    input wire we_n,
    input wire reset_n,
    // Device outputs
    output wire [15:0] dout,
    output reg ready_busy_out_n = 1'b1
);
    reg [15:0] mem [0:255];
    reg [15:0] last = 16'h0000;
    reg [15:0] pd = 16'h0000;
    reg [15:0] busy = 16'h0000;
    reg [15:0] hold = 16'h0000;
    reg we_q = 1'b1;
    reg oe_q = 1'b1;
    reg operation_toggle_bit = 1'b0;
    reg standby = 1'b0;
    wire erase_suspend_toggle_bit = 1'b0;
    wire complement_poll_bit = ~pd[7];
    wire drive = !ce_n && !oe_n;
    wire [15:0] stat = {8'h00, complement_poll_bit, operation_toggle_bit, 3'h0,
        erase_suspend_toggle_bit, 2'h0};
    // Released bus shows the inverse of the last value, never a stale copy
    assign dout = drive ? (busy != 16'h0000 ? stat : mem[addr[7:0]]) : ~last;
    // Every write is taken as a program; reset aborts at once
    always @(posedge clk) begin
        we_q <= we_n;
        oe_q <= oe_n;
        if (drive)
            last <= dout;
        hold <= reset_n ? 16'h0000 : hold + 16'h0001;
        standby <= !reset_n && hold >= STBY_CYC;
        if (!oe_n && oe_q && !ce_n && busy != 16'h0000)
            operation_toggle_bit <= ~operation_toggle_bit;
        if (!reset_n) begin
            busy <= 16'h0000;
            ready_busy_out_n <= 1'b1;
        end else if (we_n && !we_q && !ce_n && din_oe) begin
            mem[addr[7:0]] <= din;
            pd <= din;
            busy <= 16'(PROG_CYC);
            ready_busy_out_n <= 1'b0;
        end else if (busy != 16'h0000) begin
            busy <= busy - 16'h0001;
            ready_busy_out_n <= (busy == 16'h0001);
        end
    end
endmodule

/* File: fab_host_bench.sv */
`timescale 1ns/10ps
module fab_host_bench;
    reg ref_clk = 1'b0;
    reg nrst = 1'b0;
    reg [3:0] sw_addr = 4'h0;
    reg [31:0] sw_wdata = 32'h0;
    reg sw_wr = 1'b0;
    reg sw_rd = 1'b0;
    wire [31:0] sw_rdata;
    wire [21:0] fl_addr;
    wire [15:0] fl_dq_out, fl_dq_in;
    wire irq, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n, rb_n;
    integer err_count = 0;
    integer n_tests = 0;
    integer i;
    reg [31:0] seed = 32'h13;
    reg [31:0] v;
    reg [15:0] d;
    initial forever #2.5 ref_clk = ~ref_clk;
    // Short reset hold keeps the run brief
    fab_host #(.RESET_HOLD_NS(200), .READY_WAIT_NS(200)) u_dut (.ref_clk(ref_clk),
        .nrst(nrst), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
        .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq), .fl_addr(fl_addr),
        .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in),
        .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
        .fl_reset_n(fl_reset_n), .ready_busy_out_n(rb_n));
    fab_flash_model u_flash (.clk(ref_clk), .addr(fl_addr), .din(fl_dq_out),
        .din_oe(fl_dq_oe), .ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n),
        .reset_n(fl_reset_n), .dout(fl_dq_in), .ready_busy_out_n(rb_n));
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", n_tests, err_count);
            if (err_count == 0 && n_tests > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task wr(input [3:0] a, input [31:0] dv);
        begin
            @(posedge ref_clk);
            sw_addr <= a;
            sw_wdata <= dv;
            sw_wr <= 1'b1;
            @(posedge ref_clk);
            sw_wr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, output [31:0] dv);
        begin
            @(posedge ref_clk);
            sw_addr <= a;
            sw_rd <= 1'b1;
            @(posedge ref_clk);
            sw_rd <= 1'b0;
            #1 dv = sw_rdata;
        end
    endtask
    // Bounded wait for the sequencer to go idle
    task wait_idle;
        integer k;
        begin
            v = 32'h1;
            for (k = 0; k < 400 && v[0] !== 1'b0; k = k + 1)
                rd(4'h4, v);
            if (v[0] !== 1'b0) begin
                err_count = err_count + 1;
                report_and_stop;
            end
        end
    endtask
    task cmd(input [2:0] c);
        begin
            wr(4'h0, {29'h0, c});
            wait_idle;
        end
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        wr(4'h6, 32'h4);
        for (i = 0; i < 4; i = i + 1) begin
            seed = xs(seed);
            d = seed[15:0];
            wr(4'h1, {24'h0, seed[23:16]});
            wr(4'h2, {16'h0, d});
            cmd(3'h2);
            rd(4'h4, v);
            chk("busy_seen", {31'h0, v[1]}, 32'h0);
            cmd(3'h3);
            rd(4'h3, v);
            chk("poll_data", v, {16'h0, d});
            chk("irq_set", {31'h0, irq}, 32'h1);
            wr(4'h5, 32'h4);
            #1 chk("irq_clr", {31'h0, irq}, 32'h0);
            cmd(3'h1);
            rd(4'h3, v);
            chk("read_back", v, {16'h0, d});
            $display("program and poll %0d done", i);
        end
        wr(4'h6, 32'h0);
        cmd(3'h3);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        for (i = 0; i < 2; i = i + 1) begin
            if (i == 0)
                cmd(3'h2);
            cmd(3'h4);
            rd(4'h4, v);
            chk("reset_stat", v & 32'hB, 32'h2);
        end
        $display("reset tests done");
        rd(4'h9, v);
        chk("unmapped", v, 32'h0);
        rd(4'hF, v);
        chk("unmapped", v, 32'h0);
        $display("map tests done");
        report_and_stop;
    end
endmodule
bind fab_host fab_host_asserts #(.AW(AW)) u_chk (.ref_clk(ref_clk), .nrst(nrst),
    .fl_addr(fl_addr), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .fl_reset_n(fl_reset_n));
